// ### verilog/ebfp_defs.svh
`ifndef EBFP_DEFS_SVH
`define EBFP_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define EBFP_OFF_DATA      8'h00
`define EBFP_OFF_UPPER     8'h04
`define EBFP_OFF_LOWER     8'h08
`define EBFP_OFF_BURST     8'h0c
`define EBFP_OFF_IFCTL     8'h10
`define EBFP_OFF_STATUS    8'h14

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define EBFP_UPPER_SEL_BIT 15
`define EBFP_BURST_WAIT_LO 12
`define EBFP_WAIT_RESET    4'h9
`define EBFP_CLKSEL_EXT    3'h2
`define EBFP_CLKSEL_TB     3'h1
`define EBFP_CLKSEL_LO     3
`define EBFP_CLKFAC_DIV4   3'h1

`endif

// ### verilog/ebfp_pkg.sv
package ebfp_pkg;

  typedef enum logic [2:0] {
    EBFP_IDLE,
    EBFP_LATCH,
    EBFP_WAIT,
    EBFP_DONE
  } ebfp_state_t;

  typedef struct packed {
    logic [7:0] shared_addr_lines;
    logic [7:0] upper_data_addr_lines;
    logic [7:0] bus_data_byte_out;
    logic       bus_data_byte_oe;
    logic       latch_strobe_out_enable;
    logic       rom_chip_select_n;
    logic       bus_write_strobe_n;
  } ebfp_pins_t;

endpackage

// ### verilog/ebfp_flash_port.sv
// Behaviour
// - Flash reach is one megabyte through a 20-bit byte address.
// - All flash cycles run on the bus clock hclk.
// - Read starts with top address byte plus latch strobe high.
// - Next clock: middle byte on upper data lines, low byte shared.
// - Chip select low for wait count plus one cycles on reads.
// - Wait nine samples data ten cycles after new address.
// - Wait count sits in bits 15-12 of burst control.
// - First data read retried; later ones finish only with valid byte.
// - Each port read fetches exactly one byte.
// - Bus never stalls for an access; retry instead.
// - Auto-increment bit 0 of status steps lower address after each access.
// - Lower address wraps silently, no carry into upper nibble.
// - Writes use same address sequence, strobes low wait count cycles.
// - Writes posted; write during busy access is retried.
// - Clock source field bits 5-3; code 010 selects external.
// - Selected clock divided by 2 or 4 per bits 2-0.
// - Wait count resets to nine.
`timescale 1ns/1ps
`include "ebfp_defs.svh"

module ebfp_flash_port (
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [7:0]         haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  // Host retry indication for the last data port access
  output logic                    port_retry,
  // Expansion bus pins
  output ebfp_pkg::ebfp_pins_t    pins,
  input  wire logic [7:0]         bus_data_byte_in,
  // Clock source selection
  input  wire logic               external_bus_clock,
  input  wire logic               time_base_clock,
  output logic                    bus_clock_out
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [3:0]  upper_addr_nibble_r;
  logic        flash_sel_r;
  logic        lower_addr_autoinc_r;
  logic [15:0] lower_addr_word_r;
  logic [3:0]  rom_wait_count_r;
  logic [2:0]  bus_clock_select_r;
  logic [2:0]  bus_clock_divider_r;
  logic [7:0]  wdata_r;
  logic        op_write_r;
  logic [7:0]  rd_byte_r;
  logic        rd_valid_r;
  ebfp_pkg::ebfp_state_t state_r;
  logic [3:0]  cnt_r;
  logic        acc_done;

  // Address phase capture
  logic        ph_act_r;
  logic        ph_wr_r;
  logic [7:0]  ph_addr_r;
  logic        take;
  assign take = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_act_r  <= 1'b0;
      ph_wr_r   <= 1'b0;
      ph_addr_r <= 8'h00;
    end else begin
      ph_act_r  <= take;
      ph_wr_r   <= hwrite;
      ph_addr_r <= haddr;
    end
  end

  // Zero-wait slave, OKAY only; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  logic busy;
  assign busy = (state_r != ebfp_pkg::EBFP_IDLE);

  logic data_wr;
  logic data_rd;
  assign data_wr = ph_act_r && ph_wr_r && (ph_addr_r == `EBFP_OFF_DATA);
  assign data_rd = take && !hwrite && (haddr == `EBFP_OFF_DATA);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      upper_addr_nibble_r  <= 4'h0;
      flash_sel_r          <= 1'b0;
      lower_addr_autoinc_r <= 1'b0;
      rom_wait_count_r     <= `EBFP_WAIT_RESET;
      bus_clock_select_r   <= 3'h0;
      bus_clock_divider_r  <= 3'h0;
    end else if (ph_act_r && ph_wr_r) begin
      unique case (ph_addr_r)
        `EBFP_OFF_UPPER: begin
          upper_addr_nibble_r  <= hwdata[3:0];
          flash_sel_r          <= hwdata[`EBFP_UPPER_SEL_BIT];
        end
        `EBFP_OFF_STATUS: begin
          lower_addr_autoinc_r <= hwdata[0];
        end
        `EBFP_OFF_BURST: begin
          rom_wait_count_r     <= hwdata[`EBFP_BURST_WAIT_LO +: 4];
        end
        `EBFP_OFF_IFCTL: begin
          bus_clock_select_r   <= hwdata[`EBFP_CLKSEL_LO +: 3];
          bus_clock_divider_r  <= hwdata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Lower address: host load, or step once access completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lower_addr_word_r <= 16'h0000;
    end else if (ph_act_r && ph_wr_r && ph_addr_r == `EBFP_OFF_LOWER) begin
      lower_addr_word_r <= hwdata[15:0];
    end else if (acc_done && lower_addr_autoinc_r) begin
      lower_addr_word_r <= lower_addr_word_r + 16'h0001;
    end
  end

  // ----------------------------------------
  // Request decision and retry
  // ----------------------------------------
  logic start_rd;
  logic start_wr;
  logic rd_deliver;
  assign rd_deliver = data_rd && rd_valid_r;
  assign start_rd   = data_rd && !rd_valid_r && !busy && flash_sel_r;
  assign start_wr   = data_wr && !busy && flash_sel_r;

  // Retry flag of the latest data port access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_retry <= 1'b0;
    end else if (data_rd) begin
      port_retry <= !rd_valid_r;
    end else if (data_wr) begin
      port_retry <= busy;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_write_r <= 1'b0;
      wdata_r    <= 8'h00;
    end else if (start_wr) begin
      op_write_r <= 1'b1;
      wdata_r    <= hwdata[7:0];
    end else if (start_rd) begin
      op_write_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Expansion bus sequencer
  // ----------------------------------------
  // Runs on hclk, never on the external clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ebfp_pkg::EBFP_IDLE;
      cnt_r   <= 4'h0;
    end else begin
      unique case (state_r)
        ebfp_pkg::EBFP_IDLE: begin
          if (start_rd || start_wr) begin
            state_r <= ebfp_pkg::EBFP_LATCH;
          end
        end
        ebfp_pkg::EBFP_LATCH: begin
          state_r <= ebfp_pkg::EBFP_WAIT;
          cnt_r   <= op_write_r ? rom_wait_count_r - 4'h1 : rom_wait_count_r;
        end
        ebfp_pkg::EBFP_WAIT: begin
          if (cnt_r == 4'h0) begin
            state_r <= ebfp_pkg::EBFP_DONE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ebfp_pkg::EBFP_DONE: begin
          state_r <= ebfp_pkg::EBFP_IDLE;
        end
      endcase
    end
  end

  assign acc_done = (state_r == ebfp_pkg::EBFP_WAIT) && (cnt_r == 4'h0);

  // Read byte capture and hold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_byte_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else if (acc_done && !op_write_r) begin
      rd_byte_r  <= bus_data_byte_in;
      rd_valid_r <= 1'b1;
    end else if (rd_deliver) begin
      rd_valid_r <= 1'b0;
    end
  end

  // Pin drive, all registered
  logic in_wait;
  assign in_wait = (state_r == ebfp_pkg::EBFP_WAIT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins <= '{8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1};
    end else begin
      pins.latch_strobe_out_enable <= 1'b0;
      pins.rom_chip_select_n       <= 1'b1;
      pins.bus_write_strobe_n      <= 1'b1;
      pins.bus_data_byte_oe        <= 1'b0;
      if (state_r == ebfp_pkg::EBFP_IDLE && (start_rd || start_wr)) begin
        pins.shared_addr_lines       <= {4'h0, upper_addr_nibble_r};
        pins.latch_strobe_out_enable <= 1'b1;
      end else if (state_r == ebfp_pkg::EBFP_LATCH) begin
        pins.upper_data_addr_lines   <= lower_addr_word_r[15:8];
        pins.shared_addr_lines       <= lower_addr_word_r[7:0];
        pins.rom_chip_select_n       <= 1'b0;
        pins.bus_write_strobe_n      <= !op_write_r;
        // Output enable stays released for a write
        pins.latch_strobe_out_enable <= op_write_r;
        pins.bus_data_byte_oe        <= op_write_r;
        pins.bus_data_byte_out       <= wdata_r;
      end else if (in_wait && cnt_r != 4'h0) begin
        pins.rom_chip_select_n       <= 1'b0;
        pins.latch_strobe_out_enable <= op_write_r;
        pins.bus_write_strobe_n      <= !op_write_r;
        pins.bus_data_byte_oe        <= op_write_r;
      end
    end
  end

  // ----------------------------------------
  // Register read data
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      unique case (haddr)
        `EBFP_OFF_DATA:   hrdata <= {24'h000000, rd_byte_r};
        `EBFP_OFF_UPPER:  hrdata <= {16'h0000, flash_sel_r, 11'h000, upper_addr_nibble_r};
        `EBFP_OFF_LOWER:  hrdata <= {16'h0000, lower_addr_word_r};
        `EBFP_OFF_BURST:  hrdata <= {16'h0000, rom_wait_count_r, 12'h000};
        `EBFP_OFF_IFCTL:  hrdata <= {26'h0000000, bus_clock_select_r, bus_clock_divider_r};
        `EBFP_OFF_STATUS: hrdata <= {29'h00000000, rd_valid_r, busy, lower_addr_autoinc_r};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Expansion bus clock source and divider
  // ----------------------------------------
  // Sources are sampled as levels; slow clocks only, a trade for one domain
  logic [1:0] ext_sync_r;
  logic [1:0] tb_sync_r;
  logic       src;
  logic       src_d_r;
  logic [1:0] div_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_sync_r <= 2'b00;
      tb_sync_r  <= 2'b00;
    end else begin
      ext_sync_r <= {ext_sync_r[0], external_bus_clock};
      tb_sync_r  <= {tb_sync_r[0], time_base_clock};
    end
  end

  always_comb begin
    if (bus_clock_select_r == `EBFP_CLKSEL_EXT) begin
      src = ext_sync_r[1];
    end else if (bus_clock_select_r == `EBFP_CLKSEL_TB) begin
      src = tb_sync_r[1];
    end else begin
      src = 1'b1;
    end
  end

  // PCI source ticks every hclk; others tick on rising edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      src_d_r       <= 1'b0;
      div_r         <= 2'b00;
      bus_clock_out <= 1'b0;
    end else begin
      src_d_r <= src;
      // Every code other than external and time base means hclk
      if (src && (!src_d_r || (bus_clock_select_r != `EBFP_CLKSEL_EXT
          && bus_clock_select_r != `EBFP_CLKSEL_TB))) begin
        div_r <= div_r + 2'b01;
        if (bus_clock_divider_r == `EBFP_CLKFAC_DIV4) begin
          bus_clock_out <= div_r[1];
        end else begin
          bus_clock_out <= div_r[0];
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_CS_READ_LEN: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == ebfp_pkg::EBFP_LATCH && !op_write_r && rom_wait_count_r == 4'h9)
      |=> !pins.rom_chip_select_n [*8] ##1 !pins.rom_chip_select_n ##1 !pins.rom_chip_select_n
      ##1 pins.rom_chip_select_n)
    else $error("chip select length wrong on read");

  AST_STROBE_FIRST: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == ebfp_pkg::EBFP_IDLE && (start_rd || start_wr))
      |=> pins.latch_strobe_out_enable && state_r == ebfp_pkg::EBFP_LATCH)
    else $error("latch strobe missing");

  AST_ADDR_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == ebfp_pkg::EBFP_LATCH
      |=> pins.shared_addr_lines == $past(lower_addr_word_r[7:0]))
    else $error("low address byte wrong");

  AST_WRITE_RETRY: assert property (@(posedge hclk) disable iff (!hresetn)
    (data_wr && busy) |=> port_retry)
    else $error("busy write not retried");

  AST_FIRST_RETRY: assert property (@(posedge hclk) disable iff (!hresetn)
    (data_rd && !rd_valid_r) |=> port_retry)
    else $error("first read not retried");

  AST_HOLD_BYTE: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_valid_r && !data_rd) |=> rd_valid_r && $stable(rd_byte_r))
    else $error("fetched byte lost");

  AST_INC_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
    (acc_done && lower_addr_autoinc_r && lower_addr_word_r == 16'hffff && !data_wr)
      |=> lower_addr_word_r == 16'h0000 && $stable(upper_addr_nibble_r))
    else $error("wrap wrong");

  AST_NO_STALL: assert property (@(posedge hclk) disable iff (!hresetn)
    busy |-> hreadyout)
    else $error("bus stalled");

  AST_WRITE_NO_OE: assert property (@(posedge hclk) disable iff (!hresetn)
    !pins.bus_write_strobe_n |-> pins.latch_strobe_out_enable && pins.bus_data_byte_oe)
    else $error("output enable driven during write");

endmodule // ebfp_flash_port

// ### verif/ebfp_flash_model.sv
`timescale 1ns/1ps
// ------------------------------
// Flash with address latch
// ------------------------------
module ebfp_flash_model (
  // Clock
  input  wire logic            hclk,
  // Expansion bus
  input  wire ebfp_pkg::ebfp_pins_t pins,
  output logic [7:0]           bus_data_byte_in
);
  logic [7:0]  top_r;
  logic        strobe_r;
  logic [19:0] addr;
  logic [7:0]  mem [logic [19:0]];

  assign addr = {top_r[3:0], pins.upper_data_addr_lines, pins.shared_addr_lines};

  initial begin
    top_r = 8'h00;
    strobe_r = 1'b0;
    bus_data_byte_in = 8'h00;
  end

  always @(posedge hclk) begin
    strobe_r <= pins.latch_strobe_out_enable;
    // Only a rising strobe loads; writes keep it high
    if (pins.latch_strobe_out_enable && !strobe_r) top_r <= pins.shared_addr_lines;
    if (!pins.rom_chip_select_n && !pins.bus_write_strobe_n && pins.bus_data_byte_oe)
      mem[addr] = pins.bus_data_byte_out;
    // Unselected or output-disabled bus toggles, no pull
    if (pins.rom_chip_select_n || pins.latch_strobe_out_enable)
      bus_data_byte_in <= ~bus_data_byte_in;
    else if (mem.exists(addr)) bus_data_byte_in <= mem[addr];
    else bus_data_byte_in <= addr[7:0] ^ addr[15:8] ^ {4'h0, addr[19:16]} ^ 8'h5a;
  end
endmodule // ebfp_flash_model

// ### verif/ebfp_flash_port_tb_top.sv
`timescale 1ns/1ps
`include "ebfp_defs.svh"
module ebfp_flash_port_tb_top;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, port_retry;
  logic        ext_clk, tb_clk, bus_clock_out, bco_q;
  logic [7:0]  haddr, bdi;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q, seed;
  logic [19:0] a;
  logic [3:0]  wt;
  ebfp_pkg::ebfp_pins_t pins;
  int          failures, tests_run, k, n, cyc, cs_cnt, cs_len, we_cnt, we_len, bco_cnt;
  logic [23:0] cmd [16] = '{24'h5555aa, 24'h2aaa55, 24'h555580, 24'h5555aa, 24'h2aaa55,
    24'h555510, 24'h5555aa, 24'h2aaa55, 24'h555580, 24'h5555aa, 24'h2aaa55, 24'h400003,
    24'h5555aa, 24'h2aaa55, 24'h5555a0, 24'h0123c4};
  logic [13:0] ck [4] = '{14'h110c, 14'h1019, 14'h0810, 14'h0150};

  ebfp_flash_port i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_retry(port_retry),
    .pins(pins), .bus_data_byte_in(bdi), .external_bus_clock(ext_clk),
    .time_base_clock(tb_clk), .bus_clock_out(bus_clock_out));
  ebfp_flash_model i_flash (.hclk(hclk), .pins(pins), .bus_data_byte_in(bdi));

  // ------------------------------
  // Clocks and monitors
  // ------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    ext_clk = 1'b0;
    forever #80 ext_clk = ~ext_clk;
  end
  initial begin
    tb_clk = 1'b0;
    forever #120 tb_clk = ~tb_clk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    bco_q <= bus_clock_out;
    if (bus_clock_out && !bco_q) bco_cnt <= bco_cnt + 1;
    if (!pins.rom_chip_select_n) cs_cnt <= cs_cnt + 1;
    else if (cs_cnt != 0) begin
      cs_len <= cs_cnt;
      cs_cnt <= 0;
    end
    if (!pins.bus_write_strobe_n) we_cnt <= we_cnt + 1;
    else if (we_cnt != 0) begin
      we_len <= we_cnt;
      we_cnt <= 0;
    end
    // Guards against a fetch that never completes
    if (cyc == 60000) begin
      failures = failures + 1;
      stop_test();
    end
  end

  // ------------------------------
  // Tasks
  // ------------------------------
  function automatic logic [7:0] pat(input logic [19:0] x);
    return x[7:0] ^ x[15:8] ^ {4'h0, x[19:16]} ^ 8'h5a;
  endfunction
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= ad;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task set_addr(input logic [19:0] ad);
    ahb(1'b1, `EBFP_OFF_UPPER, {28'h0, ad[19:16]});
    ahb(1'b1, `EBFP_OFF_UPPER, {16'h0, 1'b1, 11'h0, ad[19:16]});
    ahb(1'b1, `EBFP_OFF_LOWER, {16'h0, ad[15:0]});
  endtask
  task fetch(input logic [7:0] e);
    ahb(1'b0, `EBFP_OFF_DATA, 32'h0);
    @(posedge hclk);
    cmp("first_retry", 32'h1, port_retry);
    for (n = 0; n < 60 && port_retry !== 1'b0; n++) begin
      ahb(1'b0, `EBFP_OFF_DATA, 32'h0);
      @(posedge hclk);
    end
    cmp("cs_len", 32'(wt) + 1, cs_len);
    cmp("byte", e, q[7:0]);
  endtask
  task wait_idle;
    for (n = 0; n < 60; n++) begin
      ahb(1'b0, `EBFP_OFF_STATUS, 32'h0);
      if (q[1] === 1'b0) break;
    end
  endtask
  task wr_flash(input logic [23:0] c);
    set_addr({4'h0, c[23:8]});
    ahb(1'b1, `EBFP_OFF_DATA, {24'h0, c[7:0]});
    @(posedge hclk);
    cmp("post", 32'h0, port_retry);
    wait_idle();
    cmp("we_len", wt, we_len);
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {failures, tests_run, cyc, cs_cnt, cs_len, we_cnt, we_len, bco_cnt} = '0;
    hsize = 3'b010;
    seed = 32'h8f20;
    hresetn = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `EBFP_OFF_BURST, 32'h0);
    cmp("wait_reset", `EBFP_WAIT_RESET, q[15:12]);
    ahb(1'b0, 8'h18, 32'h0);
    cmp("hresp", 32'h0, hresp);
    for (k = 0; k < 12; k++) begin
      a = 20'($random(seed));
      wt = (k == 0) ? 4'h9 : (k == 1) ? 4'hf : 4'($random(seed));
      if (wt == 4'h0) wt = 4'h1;
      ahb(1'b1, `EBFP_OFF_BURST, {16'h0, wt, 12'h0});
      set_addr(a);
      fetch(pat(a));
    end
    // Wrap of the lower word must leave the nibble alone
    ahb(1'b1, `EBFP_OFF_STATUS, 32'h1);
    set_addr(20'h3ffff);
    fetch(pat(20'h3ffff));
    fetch(pat(20'h30000));
    ahb(1'b0, `EBFP_OFF_LOWER, 32'h0);
    cmp("lower", 32'h1, q[15:0]);
    ahb(1'b0, `EBFP_OFF_UPPER, 32'h0);
    cmp("upper", 32'h3, q[3:0]);
    ahb(1'b1, `EBFP_OFF_STATUS, 32'h0);
    for (k = 0; k < 16; k++) wr_flash(cmd[k]);
    set_addr(20'h00123);
    fetch(8'hc4);
    wt = 4'hf;
    ahb(1'b1, `EBFP_OFF_BURST, {16'h0, wt, 12'h0});
    set_addr(20'h00200);
    ahb(1'b1, `EBFP_OFF_DATA, 32'h77);
    ahb(1'b1, `EBFP_OFF_DATA, 32'h88);
    @(posedge hclk);
    cmp("busy_write", 32'h1, port_retry);
    wait_idle();
    fetch(8'h77);
    for (k = 0; k < 4; k++) begin
      ahb(1'b1, `EBFP_OFF_IFCTL, {26'h0, ck[k][13:8]});
      set_addr(20'h12345);
      fetch(pat(20'h12345));
      n = bco_cnt;
      repeat (320) @(posedge hclk);
      n = bco_cnt - n;
      cmp("clk_rate", 32'h1, n >= ck[k][7:0] - 2 && n <= ck[k][7:0] + 2);
    end
    stop_test();
  end
endmodule // ebfp_flash_port_tb_top
